// *** src/typeb_cmd_map.svh ***
`ifndef TYPEB_CMD_MAP_SVH
`define TYPEB_CMD_MAP_SVH

// command and indicator codes
`define SLOT_LOW_NIBBLE 4'h5
`define CMD_HLTB        8'h50
`define CMD_ATTRIB      8'h1D
`define ATQB_INDICATOR  8'h50
`define HLTB_INDICATOR  8'h00
`define ATTRIB_PARAM3   8'h01
`define HLINF_GET_UID   8'h30
`define GET_UID_STATUS  8'h00

// protocol info bytes of the answer to request
`define PINFO_BYTE1     8'h77
`define PINFO_BYTE2     8'h11
`define PINFO_FWI       4'h6
`define PINFO_ADC       2'h0
`define PINFO_FO        2'h1

// field positions in the second attrib parameter
`define P2_UP_MSB       7
`define P2_UP_LSB       6
`define P2_DN_MSB       5
`define P2_DN_LSB       4

// frame lengths without crc
`define LEN_SLOT        4'h1
`define LEN_HLTB        4'h5
`define LEN_ATTRIB      4'h9
`define LEN_ATTRIB_HL   4'hA
`define LEN_ATQB        4'hC
`define LEN_ATTR_UID    4'hA
`define RX_KEEP         10

// turnaround before answering, 128 subcarrier periods
`define CLK_MHZ         20
`define TURNAROUND_NS   151000
`define TURNAROUND_CYC  ((`TURNAROUND_NS * `CLK_MHZ + 999) / 1000)

// reset values
`define CID_RESET       4'h0
`define RATE_RESET      2'h0

`endif

// *** src/typeb_cmd_pkg.sv ***
package typeb_cmd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_SLOT,
    ST_READY,
    ST_HALT,
    ST_ACTIVE
  } tag_state_t;

  typedef enum logic [1:0] {
    RESP_ATQB,
    RESP_HALT,
    RESP_ATTRIB
  } resp_kind_t;

  // one answer byte towards the frame serialiser (crc appended there)
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } tx_byte_t;

  // data rate codes picked by attrib: 0 slowest ... 3 fastest
  typedef struct packed {
    logic [1:0] up;
    logic [1:0] down;
  } rate_sel_t;

endpackage

// *** src/typeb_slot_halt_attrib_handler.sv ***
`timescale 1ns/10ps
`include "typeb_cmd_map.svh"

// Notes on behaviour
// - slot marker: one byte, low nibble 0101
// - slot number is code plus one
// - any slot order; answer on matching slot
// - ATQB: 50h, PUPI, app data, info
// - PUPI is low four UID bytes
// - app data from block 10h bytes
// - protocol info bytes 77h 11h 61h
// - up and down rates chosen independently
// - advertise 24 bytes, send at most 19
// - CID supported, NAD not supported
// - HLTB with matching PUPI halts tag
// - HLTB answer is indicator 00h
// - in HALT ignore all but WUPB
// - only matching ATTRIB enters ACTIVE
// - ATTRIB layout, third parameter 01h
// - ignore param 1; fixed turnaround, SOF/EOF
// - param 2 holds both rate fields
// - param 4 upper nibble zero, CID low
// - ATTRIB answer: indicator, optional data
// - rate codes 00..11 map 105.9..847.5
// - ATTRIB indicator upper zero, low CID
// - HLINF 30h appends 00h plus UID
module typeb_slot_halt_attrib_handler
  import typeb_cmd_pkg::*;
(
  input  wire logic                    clock_i,     // 20 MHz system clock
  input  wire logic                    reset_i,     // sync, active high
  input  wire logic                    link_clk_i,  // rx byte clock pin
  input  wire logic                    rx_frame_i,  // high during a frame
  input  wire logic [7:0]              rx_data_i,   // byte at link edge
  input  wire logic                    rx_crc_ok_i, // crc good at frame end
  input  wire logic [63:0]             uid_i,       // 64-bit identifier
  input  wire logic [31:0]             app_data_i,  // block 10h bytes 0..3
  input  wire logic                    go_ready_i,  // reqb/wupb: answer now
  input  wire logic                    go_wait_i,   // reqb/wupb: wait slot
  input  wire logic [4:0]              rand_i,      // chosen slot 1..16
  input  wire logic                    go_idle_i,   // afi mismatch
  input  wire logic                    deselect_i,  // deselect accepted
  input  wire logic                    tx_ready_i,  // serialiser takes byte
  output typeb_cmd_pkg::tx_byte_t      tx_o,        // answer byte stream
  output typeb_cmd_pkg::tag_state_t    state_o,     // tag state
  output logic [3:0]                   cid_o,       // assigned card id
  output typeb_cmd_pkg::rate_sel_t     rate_o       // rate codes
);
  import typeb_cmd_pkg::*;

  function automatic logic [7:0] uid_byte(input logic [63:0] u,
                                          input logic [3:0]  k);
    uid_byte = u[k[2:0]*8 +: 8];
  endfunction

  function automatic logic [7:0] resp_byte(input resp_kind_t  kind,
                                           input logic [3:0]  idx,
                                           input logic [63:0] u,
                                           input logic [31:0] app,
                                           input logic [3:0]  cid);
    logic [3:0] k;
    k = idx - 4'h1;
    resp_byte = 8'h00;
    case (kind)
      RESP_ATQB: begin
        if (idx == 4'h0) begin
          resp_byte = `ATQB_INDICATOR;
        end else if (idx <= 4'h4) begin
          resp_byte = uid_byte(u, k);
        end else if (idx <= 4'h8) begin
          resp_byte = app[(idx - 4'h5)*8 +: 8];
        end else if (idx == 4'h9) begin
          resp_byte = `PINFO_BYTE1;
        end else if (idx == 4'hA) begin
          resp_byte = `PINFO_BYTE2;
        end else begin
          resp_byte = {`PINFO_FWI, `PINFO_ADC,
                       `PINFO_FO};
        end
      end
      RESP_HALT: begin
        resp_byte = `HLTB_INDICATOR;
      end
      RESP_ATTRIB: begin
        if (idx == 4'h0) begin
          resp_byte = {4'h0, cid};
        end else if (idx == 4'h1) begin
          resp_byte = `GET_UID_STATUS;
        end else begin
          resp_byte = uid_byte(u, idx - 4'h2);
        end
      end
      default: begin
        resp_byte = 8'h00;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and link edge detection

  logic [1:0] clk_sync_q;
  logic       clk_prev_q;
  logic [1:0] frame_sync_q;
  logic       frame_prev_q;
  logic [7:0] data_s1_q;
  logic [7:0] data_s2_q;
  logic [1:0] crc_sync_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      clk_sync_q   <= 2'h0;
      clk_prev_q   <= 1'b0;
      frame_sync_q <= 2'h0;
      frame_prev_q <= 1'b0;
      data_s1_q    <= 8'h00;
      data_s2_q    <= 8'h00;
      crc_sync_q   <= 2'h0;
    end else begin
      clk_sync_q   <= {clk_sync_q[0], link_clk_i};
      clk_prev_q   <= clk_sync_q[1];
      frame_sync_q <= {frame_sync_q[0], rx_frame_i};
      frame_prev_q <= frame_sync_q[1];
      data_s1_q    <= rx_data_i;
      data_s2_q    <= data_s1_q;
      crc_sync_q   <= {crc_sync_q[0], rx_crc_ok_i};
    end
  end

  logic link_rise;
  logic frame_end;
  assign link_rise = clk_sync_q[1] & ~clk_prev_q & frame_sync_q[1];
  assign frame_end = frame_prev_q & ~frame_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // request capture; only the first bytes matter, longer frames count on

  logic [7:0] rx_buf_q [`RX_KEEP];
  logic [3:0] rx_len_q;
  logic       tx_busy_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_len_q <= 4'h0;
      for (int i = 0; i < `RX_KEEP; i++) begin
        rx_buf_q[i] <= 8'h00;
      end
    end else if (frame_end) begin
      rx_len_q <= 4'h0;
    end else if (link_rise && !tx_busy_q) begin
      if (rx_len_q < 4'hF) begin
        rx_len_q <= rx_len_q + 4'h1;
      end
      if (rx_len_q < 4'(`RX_KEEP)) begin
        rx_buf_q[rx_len_q] <= data_s2_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode at frame end

  tag_state_t state_q;
  logic       good_frame;
  logic       pupi_match;
  logic [4:0] slot_num;
  logic       slot_hit;
  logic       halt_hit;
  logic       attr_hit;
  logic       attr_uid;

  assign good_frame = frame_end && crc_sync_q[1] && !tx_busy_q;
  assign pupi_match = {rx_buf_q[4], rx_buf_q[3], rx_buf_q[2],
                       rx_buf_q[1]} == uid_i[31:0];
  assign slot_num   = {1'b0, rx_buf_q[0][7:4]} + 5'h01;
  // code 0000 would be slot 1, never a marker slot
  assign slot_hit   = good_frame && state_q == ST_WAIT_SLOT
                      && rx_len_q == `LEN_SLOT
                      && rx_buf_q[0][3:0] == `SLOT_LOW_NIBBLE
                      && rx_buf_q[0][7:4] != 4'h0
                      && slot_num == rand_i;
  assign halt_hit   = good_frame && state_q == ST_READY
                      && rx_len_q == `LEN_HLTB
                      && rx_buf_q[0] == `CMD_HLTB && pupi_match;
  // param 1 (byte 5) is never looked at
  assign attr_hit   = good_frame && state_q == ST_READY
                      && rx_len_q >= `LEN_ATTRIB
                      && rx_buf_q[0] == `CMD_ATTRIB
                      && rx_buf_q[7] == `ATTRIB_PARAM3
                      && rx_buf_q[8][7:4] == 4'h0
                      && pupi_match;
  assign attr_uid   = rx_len_q == `LEN_ATTRIB_HL
                      && rx_buf_q[9] == `HLINF_GET_UID;

  // halt ignores our commands; wupb arrives through go_ready/go_wait
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
    end else if (go_idle_i && state_q != ST_ACTIVE) begin
      state_q <= ST_IDLE;
    end else if (go_ready_i && state_q != ST_ACTIVE) begin
      state_q <= ST_READY;
    end else if (go_wait_i && state_q != ST_ACTIVE) begin
      state_q <= ST_WAIT_SLOT;
    end else if (deselect_i && state_q == ST_ACTIVE) begin
      state_q <= ST_HALT;
    end else begin
      case (state_q)
        ST_WAIT_SLOT: if (slot_hit) state_q <= ST_READY;
        ST_READY: begin
          if (halt_hit) begin
            state_q <= ST_HALT;
          end else if (attr_hit) begin
            state_q <= ST_ACTIVE;
          end
        end
        ST_HALT:   state_q <= ST_HALT;
        ST_IDLE:   state_q <= ST_IDLE;
        ST_ACTIVE: state_q <= ST_ACTIVE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cid_o  <= `CID_RESET;
      rate_o <= '{up: `RATE_RESET, down: `RATE_RESET};
    end else if (attr_hit) begin
      cid_o       <= rx_buf_q[8][3:0];
      rate_o.up   <= rx_buf_q[6][`P2_UP_MSB:`P2_UP_LSB];
      rate_o.down <= rx_buf_q[6][`P2_DN_MSB:`P2_DN_LSB];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_o <= ST_IDLE;
    end else begin
      state_o <= state_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer sequencing; the wait keeps the reader's turnaround fixed

  localparam int          TA_CYC = `TURNAROUND_CYC;
  localparam logic [11:0] TA_END = 12'(TA_CYC - 1);

  resp_kind_t  kind_q;
  logic [3:0]  tx_len_q;
  logic [3:0]  tx_idx_q;
  logic [11:0] ta_cnt_q;
  logic        start_atqb;

  assign start_atqb = (go_ready_i && state_q != ST_ACTIVE) || slot_hit;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_busy_q <= 1'b0;
      kind_q    <= RESP_ATQB;
      tx_len_q  <= 4'h0;
      tx_idx_q  <= 4'h0;
      ta_cnt_q  <= 12'h000;
      tx_o      <= '0;
    end else if (!tx_busy_q) begin
      ta_cnt_q <= 12'h000;
      tx_idx_q <= 4'h0;
      if (start_atqb) begin
        tx_busy_q <= 1'b1;
        kind_q    <= RESP_ATQB;
        tx_len_q  <= `LEN_ATQB;
      end else if (halt_hit) begin
        tx_busy_q <= 1'b1;
        kind_q    <= RESP_HALT;
        tx_len_q  <= 4'h1;
      end else if (attr_hit) begin
        tx_busy_q <= 1'b1;
        kind_q    <= RESP_ATTRIB;
        tx_len_q  <= attr_uid ? `LEN_ATTR_UID : 4'h1;
      end
    end else if (ta_cnt_q != TA_END) begin
      ta_cnt_q <= ta_cnt_q + 12'h001;
    end else if (!tx_o.valid || tx_ready_i) begin
      if (tx_o.valid && tx_o.last) begin
        tx_o      <= '0;
        tx_busy_q <= 1'b0;
      end else begin
        tx_o.valid <= 1'b1;
        tx_o.last  <= tx_idx_q == tx_len_q - 4'h1;
        tx_o.data  <= resp_byte(kind_q, tx_idx_q, uid_i, app_data_i,
                                cid_o);
        tx_idx_q   <= tx_idx_q + 4'h1;
      end
    end
  end

endmodule

// *** verification/typeb_handler_properties.sv ***
`timescale 1ns/10ps
module typeb_handler_properties
  import typeb_cmd_pkg::*;
(
  input  wire logic                 clock_i,    // system clock
  input  wire logic                 reset_i,    // sync reset
  input  wire logic                 go_ready_i, // answer now
  input  wire logic                 go_wait_i,  // wait for slot
  input  wire logic                 go_idle_i,  // back to idle
  input  wire logic                 deselect_i, // leave active
  input  wire logic                 tx_ready_i, // byte taken
  input  typeb_cmd_pkg::tx_byte_t   tx_o,       // answer bytes
  input  typeb_cmd_pkg::tag_state_t state_o,    // tag state
  input  wire logic [3:0]           cid_o,      // card id
  input  typeb_cmd_pkg::rate_sel_t  rate_o      // rate codes
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [4:0]  len_q;
  logic [11:0] quiet_q;
  logic        no_go;
  assign no_go = !(go_ready_i || go_wait_i || go_idle_i);
  always_ff @(posedge clock_i) begin
    if (reset_i || (tx_o.valid && tx_ready_i && tx_o.last)) len_q <= 5'h00;
    else if (tx_o.valid && tx_ready_i) len_q <= len_q + 5'h01;
  end
  // saturates so a long quiet spell cannot wrap into a false short gap
  always_ff @(posedge clock_i) begin
    if (reset_i || tx_o.valid) quiet_q <= 12'h000;
    else if (quiet_q != 12'hFFF) quiet_q <= quiet_q + 12'h001;
  end
  sequence halt_calm_s;
    state_o == ST_HALT && no_go;
  endsequence
  sequence active_calm_s;
    state_o == ST_ACTIVE && !deselect_i;
  endsequence
  byte_hold_a: assert property (tx_o.valid && !tx_ready_i |=> $stable(tx_o))
    else $error("answer byte moved before taken");
  frame_run_a: assert property (tx_o.valid && tx_ready_i && !tx_o.last |=> tx_o.valid)
    else $error("answer frame broke off");
  atqb_head_a: assert property ($rose(tx_o.valid) && state_o == ST_READY |-> tx_o.data == 8'h50)
    else $error("bad ready answer head");
  halt_head_a: assert property ($rose(tx_o.valid) && state_o == ST_HALT |-> tx_o.data == 8'h00)
    else $error("bad halt answer head");
  attrib_head_a: assert property ($rose(tx_o.valid) && state_o == ST_ACTIVE |-> tx_o.data == {4'h0, cid_o})
    else $error("bad attrib answer head");
  halt_keep_a: assert property (halt_calm_s ##1 halt_calm_s |=> state_o == ST_HALT)
    else $error("halt left without wakeup");
  active_keep_a: assert property (active_calm_s ##1 active_calm_s |=> state_o == ST_ACTIVE)
    else $error("active left without deselect");
  active_entry_a: assert property ($changed(state_o) && state_o == ST_ACTIVE |-> $past(state_o) == ST_READY)
    else $error("active entered not from ready");
  cid_load_a: assert property ($changed(cid_o) |-> ##[0:1] state_o == ST_ACTIVE)
    else $error("card id changed outside select");
  rate_load_a: assert property ($changed(rate_o) |-> ##[0:1] state_o == ST_ACTIVE)
    else $error("rate codes changed outside select");
  turn_gap_a: assert property ($rose(tx_o.valid) |-> quiet_q >= 12'hBB8)
    else $error("answer started too early");
  frame_len_a: assert property (tx_o.valid && tx_ready_i |-> len_q < 5'h11)
    else $error("answer frame too long");
endmodule

// *** verification/typeb_reader_model.sv ***
`timescale 1ns/10ps
module typeb_reader_model (
  input  wire logic       clock_i,    // system clock
  output logic            link_clk_o, // byte clock, still between frames
  output logic            frame_o,    // frame envelope
  output logic [7:0]      data_o,     // request byte
  output logic            crc_ok_o    // crc verdict
);
  initial begin
    link_clk_o = 1'b0;
    frame_o = 1'b0;
    data_o = 8'hA5;
    crc_ok_o = 1'b0;
  end
  // 400 ns link period: four system clocks each half
  task automatic send(input logic [7:0] b[$], input logic good);
    crc_ok_o <= good;
    frame_o <= 1'b1;
    foreach (b[i]) begin
      data_o <= b[i];
      repeat (4) @(posedge clock_i);
      link_clk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      link_clk_o <= 1'b0;
    end
    repeat (4) @(posedge clock_i);
    frame_o <= 1'b0;
    data_o <= ~data_o; // released line must not echo the last byte
    repeat (8) @(posedge clock_i);
  endtask
endmodule

// *** verification/typeb_slot_halt_attrib_handler_tb_top.sv ***
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  mismatches++; $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module typeb_slot_halt_attrib_handler_tb_top;
  import typeb_cmd_pkg::*;
  typedef logic [7:0] bq_t[$];
  logic       clock_i, reset_i, link_clk_i, rx_frame_i, rx_crc_ok_i, tx_ready_i;
  logic [7:0] rx_data_i;
  logic [63:0] uid_i;
  logic [31:0] app_data_i;
  logic [4:0] rand_i;
  logic       go_ready_i, go_wait_i, go_idle_i, deselect_i;
  logic [3:0] cid_o;
  tx_byte_t   tx_o;
  tag_state_t state_o;
  rate_sel_t  rate_o;
  int         comparisons = 0;
  int         mismatches = 0;
  typeb_slot_halt_attrib_handler typeb_slot_halt_attrib_handler_inst (
    .clock_i, .reset_i, .link_clk_i, .rx_frame_i, .rx_data_i, .rx_crc_ok_i,
    .uid_i, .app_data_i, .go_ready_i, .go_wait_i, .rand_i, .go_idle_i,
    .deselect_i, .tx_ready_i, .tx_o, .state_o,
    .cid_o, .rate_o);
  typeb_reader_model typeb_reader_model_inst (.clock_i, .link_clk_o(link_clk_i),
    .frame_o(rx_frame_i), .data_o(rx_data_i), .crc_ok_o(rx_crc_ok_i));
  ////////////////////////////////////////////////////////////////////////////
  function automatic bq_t pupi(input logic [7:0] cmd);
    bq_t q;
    q.push_back(cmd);
    for (int i = 0; i < 4; i++) q.push_back(uid_i[8*i +: 8]);
    return q;
  endfunction
  function automatic bq_t atqb();
    bq_t q;
    q = pupi(8'h50);
    for (int i = 0; i < 4; i++) q.push_back(app_data_i[8*i +: 8]);
    q.push_back(8'h77);
    q.push_back(8'h11);
    q.push_back(8'h61);
    return q;
  endfunction
  task automatic pulse(input logic [3:0] m);
    {deselect_i, go_idle_i, go_wait_i, go_ready_i} <= m;
    @(posedge clock_i);
    {deselect_i, go_idle_i, go_wait_i, go_ready_i} <= 4'h0;
    repeat (3) @(posedge clock_i);
  endtask
  // empty list: no byte may appear for longer than the turnaround
  task automatic expect_frame(input bq_t e);
    int n;
    n = 0;
    for (int t = 0; t < 3300 && (n < e.size() || e.size() == 0); t++) begin
      @(posedge clock_i);
      if (tx_o.valid === 1'b1 && tx_ready_i === 1'b1) begin
        `CHECK("tx byte", e[n], tx_o.data)
        `CHECK("tx last", 1'(n == e.size() - 1), tx_o.last)
        n++;
      end
      tx_ready_i <= 1'($urandom);
    end
    `CHECK("tx count", e.size(), n)
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    repeat (80000) @(posedge clock_i);
    mismatches++;
    stop_test();
  end
  initial begin
    bq_t f;
    logic [7:0] p2;
    logic [3:0] cid;
    void'($urandom(32'hDB7F3C6F));
    reset_i = 1'b1;
    {deselect_i, go_idle_i, go_wait_i, go_ready_i} = 4'h0;
    tx_ready_i = 1'b0;
    rand_i = 5'h02;
    uid_i = {$urandom, $urandom};
    app_data_i = $urandom;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    `CHECK("reset", 21'h000000, {state_o, cid_o, rate_o, tx_o})
    pulse(4'h1);
    expect_frame(atqb());
    f = pupi(8'h50);
    f[1] = ~f[1];
    typeb_reader_model_inst.send(f, 1'b1);
    expect_frame('{});
    typeb_reader_model_inst.send(pupi(8'h50), 1'b0);
    expect_frame('{});
    typeb_reader_model_inst.send(pupi(8'h50), 1'b1);
    expect_frame('{8'h00});
    `CHECK("halted", ST_HALT, state_o)
    f = pupi(8'h1D);
    f.push_back(8'h00);
    f.push_back(8'h00);
    f.push_back(8'h01);
    f.push_back(8'h00);
    typeb_reader_model_inst.send(f, 1'b1);
    expect_frame('{});
    for (int k = 0; k < 2; k++) begin
      uid_i <= {$urandom, $urandom};
      app_data_i <= $urandom;
      rand_i <= k ? 5'(2 + $urandom % 15) : 5'h10;
      pulse(4'h2);
      `CHECK("waiting", ST_WAIT_SLOT, state_o)
      typeb_reader_model_inst.send('{8'h05}, 1'b1);
      expect_frame('{});
      if (k == 0) begin
        typeb_reader_model_inst.send('{8'h15}, 1'b1);
        expect_frame('{});
      end
      f = '{k ? {4'(rand_i - 5'h01), 4'h5} : 8'hF5};
      typeb_reader_model_inst.send(f, 1'b1);
      expect_frame(atqb());
      p2 = 8'($urandom);
      cid = 4'($urandom % 15);
      f = pupi(8'h1D);
      f.push_back(8'($urandom));
      f.push_back(p2);
      f.push_back(8'h01);
      f.push_back({4'h0, cid});
      f.push_back(k ? 8'h31 : 8'h30);
      typeb_reader_model_inst.send(f, 1'b1);
      f = '{{4'h0, cid}};
      if (k == 0) f.push_back(8'h00);
      for (int i = 0; i < 8 && k == 0; i++) f.push_back(uid_i[8*i +: 8]);
      expect_frame(f);
      `CHECK("active", ST_ACTIVE, state_o)
      `CHECK("cid", cid, cid_o)
      `CHECK("rate", {p2[7:6], p2[5:4]}, rate_o)
      pulse(4'h8);
      `CHECK("deselected", ST_HALT, state_o)
    end
    pulse(4'h4);
    `CHECK("idle", ST_IDLE, state_o)
    stop_test();
  end
endmodule
bind typeb_slot_halt_attrib_handler typeb_handler_properties
  typeb_handler_properties_inst (.clock_i, .reset_i, .go_ready_i, .go_wait_i,
  .go_idle_i, .deselect_i, .tx_ready_i, .tx_o, .state_o, .cid_o, .rate_o);
